// ===== rtl/temp_sense_pkg.sv
// Purpose: Shared constants and types of the temperature sensor core
// Assumes: 250 MHz ref_clk, 16-bit result at 128 LSB per degree
// Notes: Register pointers, config fields, timing and state encodings
// Contract
// R1 - Fast first conversion of about 6 ms
// R2 - Fast result above 147 C asserts critical
// R3 - Fast result above 64 C asserts limit
// R4 - Continuous conversion is the default mode
// R5 - Continuous conversion lasts about 240 ms
// R6 - Back-to-back conversions, each result stored
// R7 - Reads return latest completed result
// R8 - Conversions timed internally, serial clock only for access
// R9 - Three 16-bit setpoints; limit alert outside high/low
// R10 - Critical alert when result exceeds critical setpoint
// R11 - Alert polarity selectable in configuration
// R12 - Alerts selectable comparator or interrupt behaviour
// R13 - Limit alert defaults active-low comparator
// R14 - Critical alert defaults active-low
// R15 - Four modes: continuous, single, per-second, shutdown
// R16 - Mode bits 6:5 equal 01 mean single
// R17 - Single converts once, then shuts down
// R18 - Controller waits 240 ms before reading
// R19 - Each single-mode write starts new conversion
// R20 - Registers accessed as I2C target
// R21 - Two select pins choose target address
// R22 - 10 per-second, 11 shutdown, 00 continuous
// R23 - Per-second: 60 ms conversion, idle rest
// R24 - Interrupt behaviour: any read clears alerts
// R25 - Bit 7 selects 16-bit, else flags
// R26 - Alerts evaluated only at conversion completion
// R27 - Single result stored, readable while shut down
`default_nettype none

package temp_sense_pkg;
	localparam logic [7:0] PTR_TEMP_MSB = 8'h00;
	localparam logic [7:0] PTR_TEMP_LSB = 8'h01;
	localparam logic [7:0] PTR_STATUS = 8'h02;
	localparam logic [7:0] PTR_CONFIG = 8'h03;
	localparam logic [7:0] PTR_HIGH_MSB = 8'h04;
	localparam logic [7:0] PTR_HIGH_LSB = 8'h05;
	localparam logic [7:0] PTR_LOW_MSB = 8'h06;
	localparam logic [7:0] PTR_LOW_LSB = 8'h07;
	localparam logic [7:0] PTR_CRIT_MSB = 8'h08;
	localparam logic [7:0] PTR_CRIT_LSB = 8'h09;

	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int RES16_BIT = 7;
	localparam int MODE_HI_BIT = 6;
	localparam int MODE_LO_BIT = 5;
	localparam int INTR_MODE_BIT = 4;
	localparam int CT_POL_BIT = 3;
	localparam int INT_POL_BIT = 2;

	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_SPS = 2'h2;
	localparam logic [1:0] MODE_SHUT = 2'h3;

	localparam int LSB_PER_DEGC = 128;
	localparam int FAST_CRIT_DEGC = 147;
	localparam int FAST_INT_DEGC = 64;
	localparam logic [15:0] FAST_CRIT_LIMIT = 16'(FAST_CRIT_DEGC * LSB_PER_DEGC);
	localparam logic [15:0] FAST_INT_LIMIT = 16'(FAST_INT_DEGC * LSB_PER_DEGC);
	localparam logic [15:0] CRIT_RESET = 16'h4980;
	localparam logic [15:0] HIGH_RESET = 16'h2000;
	localparam logic [15:0] LOW_RESET = 16'h0500;

	// Arbitrary base value
	localparam logic [6:0] ADDR_BASE = 7'h48;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam int unsigned CLK_KHZ = 250000;
	localparam int unsigned FAST_MS = 6;
	localparam int unsigned CONV_MS = 240;
	localparam int unsigned SPS_CONV_MS = 60;
	localparam int unsigned SPS_PERIOD_MS = 1000;
	localparam logic [31:0] FAST_CYC = 32'(FAST_MS * CLK_KHZ);
	localparam logic [31:0] CONV_CYC = 32'(CONV_MS * CLK_KHZ);
	localparam logic [31:0] SPS_CONV_CYC = 32'(SPS_CONV_MS * CLK_KHZ);
	localparam logic [31:0] SPS_IDLE_CYC =
		32'((SPS_PERIOD_MS - SPS_CONV_MS) * CLK_KHZ);

	typedef enum logic [1:0] {
		cv_fast = 2'h0,
		cv_convert = 2'h1,
		cv_idle = 2'h2,
		cv_shutdown = 2'h3
	} conv_state_e;

	typedef enum logic [2:0] {
		i2_idle = 3'h0,
		i2_addr = 3'h1,
		i2_addr_ack = 3'h2,
		i2_write = 3'h3,
		i2_write_ack = 3'h4,
		i2_read = 3'h5,
		i2_read_ack = 3'h6
	} i2c_state_e;
endpackage : temp_sense_pkg

`default_nettype wire

// ===== rtl/i2c_register_port.sv
// Purpose: I2C target byte engine, serial clock sampled by ref_clk
// Assumes: SCL and SDA arrive unsynchronised; no clock stretching
// Notes: Pointer handling lives in the parent
`default_nettype none

module i2c_register_port (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [6:0] dev_addr,
	output logic wr_strobe,
	output logic wr_first,
	output logic [7:0] wr_byte,
	output logic rd_strobe,
	input wire logic [7:0] rd_byte
);
	temp_sense_pkg::i2c_state_e state, next_state;
	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic [3:0] cnt, next_cnt;
	logic [7:0] tx, next_tx, next_shreg;
	logic rw, next_rw, mack, next_mack, next_first, next_oe_n;
	logic next_wr, next_rd;

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire byte_full = (cnt == temp_sense_pkg::BYTE_BITS);
	wire shifting = (state == temp_sense_pkg::i2_addr) ||
		(state == temp_sense_pkg::i2_write);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shreg = wr_byte;
		next_tx = tx;
		next_oe_n = sda_oe_n;
		next_rw = rw;
		next_first = wr_first;
		next_mack = mack;
		next_wr = 1'b0;
		next_rd = 1'b0;
		if (start_seen) begin
			next_state = temp_sense_pkg::i2_addr;
			next_cnt = 4'h0;
			next_oe_n = 1'b1;
		end else if (stop_seen) begin
			next_state = temp_sense_pkg::i2_idle;
			next_oe_n = 1'b1;
		end else if (scl_rise) begin
			if (shifting) begin
				next_shreg = {wr_byte[6:0], sda_s2};
				next_cnt = cnt + 4'h1;
			end
			if (state == temp_sense_pkg::i2_read_ack) begin
				next_mack = ~sda_s2;
			end
		end else if (scl_fall) begin
			case (state)
				temp_sense_pkg::i2_addr: begin
					if (byte_full && wr_byte[7:1] == dev_addr) begin // [R20] [R21]
						next_state = temp_sense_pkg::i2_addr_ack;
						next_oe_n = 1'b0;
						next_rw = wr_byte[0];
					end else if (byte_full) begin
						next_state = temp_sense_pkg::i2_idle;
					end
				end
				temp_sense_pkg::i2_write: begin
					if (byte_full) begin
						next_state = temp_sense_pkg::i2_write_ack;
						next_oe_n = 1'b0;
						next_wr = 1'b1;
					end
				end
				temp_sense_pkg::i2_write_ack: begin
					next_state = temp_sense_pkg::i2_write;
					next_oe_n = 1'b1;
					next_cnt = 4'h0;
					next_first = 1'b0;
				end
				temp_sense_pkg::i2_addr_ack, temp_sense_pkg::i2_read_ack: begin
					if (state == temp_sense_pkg::i2_addr_ack && !rw) begin
						next_state = temp_sense_pkg::i2_write;
						next_oe_n = 1'b1;
						next_cnt = 4'h0;
						next_first = 1'b1;
					end else if (state == temp_sense_pkg::i2_addr_ack || mack) begin
						next_state = temp_sense_pkg::i2_read;
						next_tx = rd_byte;
						next_oe_n = rd_byte[7];
						next_rd = 1'b1;
						next_cnt = 4'h1;
					end else begin
						next_state = temp_sense_pkg::i2_idle;
						next_oe_n = 1'b1;
					end
				end
				temp_sense_pkg::i2_read: begin
					if (byte_full) begin
						next_state = temp_sense_pkg::i2_read_ack;
						next_oe_n = 1'b1;
					end else begin
						next_oe_n = tx[6];
						next_tx = {tx[6:0], 1'b0};
						next_cnt = cnt + 4'h1;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		{scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
		{sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= temp_sense_pkg::i2_idle;
			cnt <= 4'h0;
			tx <= 8'h00;
			wr_byte <= 8'h00;
			rw <= 1'b0;
			mack <= 1'b0;
			wr_first <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			tx <= next_tx;
			wr_byte <= next_shreg;
			rw <= next_rw;
			mack <= next_mack;
			wr_first <= next_first;
			sda_oe_n <= next_oe_n;
			sda_out <= 1'b0;
			wr_strobe <= next_wr;
			rd_strobe <= next_rd;
		end
	end
endmodule : i2c_register_port

`default_nettype wire

// ===== rtl/temp_conversion_and_limit_alerts.sv
// Purpose: Conversion sequencing, register file and alert outputs
// Assumes: temp_sample comes from the converter on ref_clk
// Notes: Serial pins and select pins pass two flip-flops first
`default_nettype none

module temp_conversion_and_limit_alerts #(
	parameter logic [31:0] FAST_CYC = temp_sense_pkg::FAST_CYC,
	parameter logic [31:0] CONV_CYC = temp_sense_pkg::CONV_CYC,
	parameter logic [31:0] SPS_CONV_CYC = temp_sense_pkg::SPS_CONV_CYC,
	parameter logic [31:0] SPS_IDLE_CYC = temp_sense_pkg::SPS_IDLE_CYC,
	parameter logic [6:0] ADDR_BASE = temp_sense_pkg::ADDR_BASE
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic address_select_low,
	input wire logic address_select_high,
	input wire logic [15:0] temp_sample,
	output logic critical_alert_output,
	output logic critical_alert_output_oe_n,
	output logic limit_alert_output,
	output logic limit_alert_output_oe_n
);
	if (FAST_CYC < 32'h2 || CONV_CYC < 32'h2 || SPS_CONV_CYC < 32'h2 ||
		SPS_IDLE_CYC < 32'h2) begin : g_bad_timing
		$error("Conversion timing counts must be at least two");
	end

	temp_sense_pkg::conv_state_e state, next_state;
	logic [31:0] timer, next_timer;
	logic [7:0] pointer, config_reg;
	logic [15:0] crit_sp, high_sp, low_sp, temp_value;
	logic crit_active, limit_active;
	logic a0_s1, a0_s2, a1_s1, a1_s2;
	logic wr_strobe, wr_first, rd_strobe;
	logic [7:0] wr_byte;

	function automatic logic [7:0] read_mux(
		input logic [7:0] ptr,
		input logic [15:0] temp,
		input logic [7:0] status,
		input logic [7:0] cfg,
		input logic [15:0] hi,
		input logic [15:0] lo,
		input logic [15:0] cr
	);
		case (ptr)
			temp_sense_pkg::PTR_TEMP_MSB: read_mux = temp[15:8];
			temp_sense_pkg::PTR_TEMP_LSB: read_mux = temp[7:0];
			temp_sense_pkg::PTR_STATUS: read_mux = status;
			temp_sense_pkg::PTR_CONFIG: read_mux = cfg;
			temp_sense_pkg::PTR_HIGH_MSB: read_mux = hi[15:8];
			temp_sense_pkg::PTR_HIGH_LSB: read_mux = hi[7:0];
			temp_sense_pkg::PTR_LOW_MSB: read_mux = lo[15:8];
			temp_sense_pkg::PTR_LOW_LSB: read_mux = lo[7:0];
			temp_sense_pkg::PTR_CRIT_MSB: read_mux = cr[15:8];
			temp_sense_pkg::PTR_CRIT_LSB: read_mux = cr[7:0];
			default: read_mux = 8'h00;
		endcase
	endfunction : read_mux

	wire [6:0] dev_addr = {ADDR_BASE[6:2], a1_s2, a0_s2}; // [R21]
	wire busy = (state == temp_sense_pkg::cv_fast) ||
		(state == temp_sense_pkg::cv_convert);
	wire [7:0] status_byte = {crit_active, limit_active, 5'h00, busy};
	wire [7:0] rd_byte = read_mux(pointer, temp_value, status_byte,
		config_reg, high_sp, low_sp, crit_sp); // [R7]

	wire reg_wr = wr_strobe & ~wr_first;
	wire cfg_wr = reg_wr && (pointer == temp_sense_pkg::PTR_CONFIG);
	wire [1:0] mode = config_reg[temp_sense_pkg::MODE_HI_BIT:
		temp_sense_pkg::MODE_LO_BIT];
	wire [1:0] new_mode = wr_byte[temp_sense_pkg::MODE_HI_BIT:
		temp_sense_pkg::MODE_LO_BIT];
	wire intr_mode = config_reg[temp_sense_pkg::INTR_MODE_BIT];
	wire res16 = config_reg[temp_sense_pkg::RES16_BIT];

	// Conversion length follows the state and the per-second option
	wire [31:0] limit = (state == temp_sense_pkg::cv_fast) ? FAST_CYC : // [R1]
		(state == temp_sense_pkg::cv_idle) ? SPS_IDLE_CYC : // [R23]
		(mode == temp_sense_pkg::MODE_SPS) ? SPS_CONV_CYC : CONV_CYC; // [R5]
	wire tick_end = (timer == limit - 32'h1);
	wire conv_done = busy && tick_end; // [R8]
	wire was_fast = (state == temp_sense_pkg::cv_fast);

	wire signed [15:0] sample = temp_sample;
	wire crit_hit = was_fast ?
		sample > $signed(temp_sense_pkg::FAST_CRIT_LIMIT) : // [R2]
		sample > $signed(crit_sp); // [R10]
	wire high_hit = was_fast ?
		sample > $signed(temp_sense_pkg::FAST_INT_LIMIT) : // [R3]
		sample > $signed(high_sp); // [R9]
	wire low_hit = ~was_fast && (sample < $signed(low_sp)); // [R9]
	wire limit_hit = high_hit | low_hit;

	// Interrupt behaviour latches and clears on any read; set wins
	wire next_crit = intr_mode ? // [R12]
		(conv_done & crit_hit) | (crit_active & ~rd_strobe) : // [R24]
		(conv_done ? crit_hit : crit_active); // [R26]
	wire next_limit = intr_mode ?
		(conv_done & limit_hit) | (limit_active & ~rd_strobe) : // [R24]
		(conv_done ? limit_hit : limit_active); // [R26]
	wire [15:0] stored = res16 ? temp_sample : // [R25]
		{temp_sample[15:3], crit_hit, high_hit, low_hit};

	always_comb begin
		next_state = state;
		next_timer = timer + 32'h1;
		if (cfg_wr) begin
			next_timer = 32'h0;
			next_state = (new_mode == temp_sense_pkg::MODE_SHUT) ? // [R22]
				temp_sense_pkg::cv_shutdown :
				temp_sense_pkg::cv_convert; // [R16] [R19]
		end else begin
			case (state)
				temp_sense_pkg::cv_fast, temp_sense_pkg::cv_convert: begin
					if (tick_end) begin
						next_timer = 32'h0;
						case (mode) // [R15]
							temp_sense_pkg::MODE_SINGLE:
								next_state = temp_sense_pkg::cv_shutdown; // [R17]
							temp_sense_pkg::MODE_SPS:
								next_state = temp_sense_pkg::cv_idle; // [R23]
							temp_sense_pkg::MODE_SHUT:
								next_state = temp_sense_pkg::cv_shutdown;
							default:
								next_state = temp_sense_pkg::cv_convert; // [R6]
						endcase
					end
				end
				temp_sense_pkg::cv_idle: begin
					if (tick_end) begin
						next_timer = 32'h0;
						next_state = temp_sense_pkg::cv_convert;
					end
				end
				temp_sense_pkg::cv_shutdown: next_timer = 32'h0;
				default: begin
					next_timer = 32'h0;
					next_state = temp_sense_pkg::cv_fast;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		{a0_s1, a0_s2} <= {address_select_low, a0_s1};
		{a1_s1, a1_s2} <= {address_select_high, a1_s1};
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= temp_sense_pkg::cv_fast; // [R1] [R4]
			timer <= 32'h0;
			temp_value <= 16'h0000;
			crit_active <= 1'b0;
			limit_active <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			if (conv_done) begin
				temp_value <= stored; // [R6] [R27]
			end
			crit_active <= next_crit;
			limit_active <= next_limit;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pointer <= temp_sense_pkg::PTR_TEMP_MSB;
			config_reg <= temp_sense_pkg::CONFIG_RESET; // [R4] [R13] [R14]
			crit_sp <= temp_sense_pkg::CRIT_RESET;
			high_sp <= temp_sense_pkg::HIGH_RESET;
			low_sp <= temp_sense_pkg::LOW_RESET;
		end else begin
			if (wr_strobe && wr_first) begin
				pointer <= wr_byte;
			end else if (reg_wr || rd_strobe) begin
				pointer <= pointer + 8'h01;
			end
			if (reg_wr) begin
				case (pointer)
					temp_sense_pkg::PTR_CONFIG: config_reg <= wr_byte;
					temp_sense_pkg::PTR_HIGH_MSB: high_sp[15:8] <= wr_byte;
					temp_sense_pkg::PTR_HIGH_LSB: high_sp[7:0] <= wr_byte;
					temp_sense_pkg::PTR_LOW_MSB: low_sp[15:8] <= wr_byte;
					temp_sense_pkg::PTR_LOW_LSB: low_sp[7:0] <= wr_byte;
					temp_sense_pkg::PTR_CRIT_MSB: crit_sp[15:8] <= wr_byte;
					temp_sense_pkg::PTR_CRIT_LSB: crit_sp[7:0] <= wr_byte;
					default: ;
				endcase
			end
		end
	end

	// Open drain: pulled low when the active level is low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			critical_alert_output <= 1'b0;
			critical_alert_output_oe_n <= 1'b1;
			limit_alert_output <= 1'b0;
			limit_alert_output_oe_n <= 1'b1;
		end else begin
			critical_alert_output <= 1'b0;
			critical_alert_output_oe_n <= ~(crit_active ^
				config_reg[temp_sense_pkg::CT_POL_BIT]); // [R11]
			limit_alert_output <= 1'b0;
			limit_alert_output_oe_n <= ~(limit_active ^
				config_reg[temp_sense_pkg::INT_POL_BIT]); // [R11]
		end
	end

	i2c_register_port u_port (
		.ref_clk(ref_clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.dev_addr(dev_addr),
		.wr_strobe(wr_strobe),
		.wr_first(wr_first),
		.wr_byte(wr_byte),
		.rd_strobe(rd_strobe),
		.rd_byte(rd_byte)
	); // [R20]

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	reset_start_a: assert property ($fell(rst) |->
		state == temp_sense_pkg::cv_fast && timer == 32'h0 &&
		mode == temp_sense_pkg::MODE_CONT) // [R4]
		else $error("Not in fast conversion after reset");
	fast_crit_a: assert property (conv_done && was_fast &&
		sample > $signed(temp_sense_pkg::FAST_CRIT_LIMIT) |=>
		crit_active ##1 (critical_alert_output_oe_n ==
		config_reg[temp_sense_pkg::CT_POL_BIT])) // [R2]
		else $error("Fast hot result did not raise critical alert");
	fast_int_a: assert property (conv_done && was_fast &&
		sample > $signed(temp_sense_pkg::FAST_INT_LIMIT) |=>
		limit_active) // [R3]
		else $error("Fast warm result did not raise limit alert");
	cont_restart_a: assert property (conv_done && !cfg_wr &&
		mode == temp_sense_pkg::MODE_CONT |=>
		state == temp_sense_pkg::cv_convert && timer == 32'h0 &&
		temp_value[15:3] == $past(temp_sample[15:3])) // [R6]
		else $error("Continuous conversion did not restart and store");
	single_shut_a: assert property (conv_done && !cfg_wr &&
		mode == temp_sense_pkg::MODE_SINGLE |=>
		state == temp_sense_pkg::cv_shutdown [*2]) // [R17]
		else $error("Single conversion did not end in shutdown");
	single_trig_a: assert property (cfg_wr &&
		new_mode == temp_sense_pkg::MODE_SINGLE |=>
		state == temp_sense_pkg::cv_convert && timer == 32'h0) // [R19]
		else $error("Single-mode write did not start a conversion");
	shut_hold_a: assert property (state == temp_sense_pkg::cv_shutdown &&
		!cfg_wr |=> $stable(temp_value)) // [R27]
		else $error("Stored result changed during shutdown");
	intr_clear_a: assert property (rd_strobe && intr_mode && !conv_done |=>
		!crit_active && !limit_active) // [R24]
		else $error("Read did not clear interrupt alerts");
	comp_hold_a: assert property (!conv_done && !intr_mode |=>
		$stable(crit_active) && $stable(limit_active)) // [R26]
		else $error("Comparator alert changed between conversions");
	pin_pol_a: assert property (1'b1 |=> limit_alert_output_oe_n ==
		~($past(limit_active) ^
		$past(config_reg[temp_sense_pkg::INT_POL_BIT]))) // [R11]
		else $error("Limit pin does not follow flag and polarity");

	fast_done_c: cover property (conv_done && was_fast);
	single_done_c: cover property (conv_done &&
		mode == temp_sense_pkg::MODE_SINGLE);
	sps_idle_c: cover property (state == temp_sense_pkg::cv_idle && tick_end);
	intr_read_c: cover property (rd_strobe && intr_mode && crit_active);
endmodule : temp_conversion_and_limit_alerts

`default_nettype wire

// ===== testbench/i2c_controller_model.sv
// Purpose: I2C controller model facing the sensor's target port
// Assumes: Open-drain lines with pull-ups; SCL period 16 ref_clk
// Notes: Lines change only at ref_clk falling edges
`default_nettype none

module i2c_controller_model (
	input wire logic ref_clk,
	input wire logic sda_wire,
	output logic scl_drv,
	output logic sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_drv = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	// Also a repeated start: SDA falls while SCL high
	task automatic start();
		sda_pull = 1'b0;
		tick(4);
		scl_drv = 1'b1;
		tick(4);
		sda_pull = 1'b1;
		tick(4);
		scl_drv = 1'b0;
		tick(4);
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		tick(4);
		scl_drv = 1'b1;
		tick(4);
		sda_pull = 1'b0;
		tick(8);
	endtask : stop
	// Set while SCL low, sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		sda_pull = ~b;
		tick(4);
		scl_drv = 1'b1;
		tick(4);
		r = sda_wire;
		tick(4);
		scl_drv = 1'b0;
		tick(4);
	endtask : bit_x
	task automatic byte_x(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(a, ack);
	endtask : byte_x
	// Pointer write, then a data byte or a one-byte read
	task automatic access(input logic [6:0] adr, input logic [7:0] ptr,
		input logic rd, input logic [7:0] wd,
		output logic [7:0] q, output logic ok);
		logic a0, a1, a2, nack;
		logic [7:0] dummy;
		start();
		byte_x({adr, 1'b0}, 1'b1, dummy, a0);
		byte_x(ptr, 1'b1, dummy, a1);
		q = 8'h00;
		if (rd) begin
			start();
			byte_x({adr, 1'b1}, 1'b1, dummy, a2);
			byte_x(8'hff, 1'b1, q, nack);
		end else begin
			byte_x(wd, 1'b1, dummy, a2);
		end
		stop();
		ok = ~(a0 | a1 | a2);
	endtask : access
endmodule : i2c_controller_model

`default_nettype wire

// ===== testbench/temp_conversion_and_limit_alerts_tb_top.sv
// Purpose: Self-checking bench of conversion sequencing and alerts
// Assumes: Shortened conversion counts; controller model on I2C
// Notes: Expected values come from a model of the register behaviour
`default_nettype none

module temp_conversion_and_limit_alerts_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic scl_drv, sda_pull, sda_out, sda_oe_n, crit_oe_n, lim_oe_n, ok;
	logic crit_d, lim_d;
	logic a_lo = 1'b0;
	logic a_hi = 1'b0;
	logic [15:0] temp_sample = 16'h4981;
	logic [7:0] cfg = 8'h00;
	logic [15:0] hi_sp = 16'h2000;
	logic [15:0] lo_sp = 16'h0500;
	logic [15:0] cr_sp = 16'h4980;
	logic [15:0] s, t, expv;
	logic [31:0] seed = 32'h37;
	logic [7:0] q;
	logic [7:0] rst_vals [7] = '{8'h00, 8'h20, 8'h00, 8'h05, 8'h00,
		8'h49, 8'h80};
	int err_count = 0;
	int n_checks = 0;
	wire logic sda_wire = ~sda_pull & (sda_oe_n | sda_out);

	always #2 ref_clk = ~ref_clk;

	temp_conversion_and_limit_alerts #(.FAST_CYC(32'h28),
		.CONV_CYC(32'hc8), .SPS_CONV_CYC(32'h3c), .SPS_IDLE_CYC(32'h64)
	) temp_conversion_and_limit_alerts_inst (.ref_clk(ref_clk),
		.rst(rst), .scl_in(scl_drv), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.address_select_low(a_lo), .address_select_high(a_hi),
		.temp_sample(temp_sample), .critical_alert_output(crit_d),
		.critical_alert_output_oe_n(crit_oe_n),
		.limit_alert_output(lim_d), .limit_alert_output_oe_n(lim_oe_n));

	i2c_controller_model i2c_controller_model_inst (.ref_clk(ref_clk),
		.sda_wire(sda_wire), .scl_drv(scl_drv), .sda_pull(sda_pull));

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	function automatic logic [2:0] hits(input logic [15:0] v);
		return {$signed(v) > $signed(cr_sp), $signed(v) > $signed(hi_sp),
			$signed(v) < $signed(lo_sp)};
	endfunction : hits
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : idle
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic reg_acc(input logic [7:0] p, input logic r,
		input logic [7:0] wd);
		i2c_controller_model_inst.access({temp_sense_pkg::ADDR_BASE[6:2],
			a_hi, a_lo}, p, r, wd, q, ok);
		check(16'(ok), 16'h0001);
	endtask : reg_acc
	task automatic cfg_w(input logic [7:0] v);
		reg_acc(8'h03, 1'b0, v);
		cfg = v;
	endtask : cfg_w
	// Two byte reads, compared with the stored form of v
	task automatic temp_is(input logic [15:0] v);
		reg_acc(8'h00, 1'b1, 8'h00);
		t[15:8] = q;
		reg_acc(8'h01, 1'b1, 8'h00);
		t[7:0] = q;
		check(t, cfg[7] ? v : {v[15:3], hits(v)});
	endtask : temp_is
	task automatic pins_are(input logic [2:0] h);
		check(16'({crit_oe_n, lim_oe_n}),
			16'({cfg[3] ~^ h[2], cfg[2] ~^ (h[1] | h[0])}));
		check(16'({crit_d, lim_d}), 16'h0000);
	endtask : pins_are

	initial begin
		idle(100000);
		err_count++;
		close_out();
	end

	initial begin
		idle(2);
		rst = 1'b0;
		idle(30);
		check(16'({sda_oe_n, crit_oe_n, lim_oe_n}), 16'h0007);
		idle(20);
		pins_are(3'b110);
		foreach (rst_vals[i]) begin
			reg_acc(8'(i + 3), 1'b1, 8'h00);
			check(16'(q), 16'(rst_vals[i]));
		end
		temp_is(temp_sample);
		for (int k = 0; k < 6; k++) begin
			if (k == 3) begin
				cfg_w(8'h8c);
			end
			s = rnd();
			hi_sp[15:8] = s[15:8] ^ 8'h10;
			reg_acc(8'h04, 1'b0, hi_sp[15:8]);
			temp_sample = s;
			idle(450);
			temp_is(s);
			pins_are(hits(s));
		end
		s = rnd();
		temp_sample = s;
		cfg_w(8'h20);
		idle(220);
		temp_is(s);
		temp_sample = ~s;
		idle(450);
		temp_is(s);
		cfg_w(8'h20);
		idle(220);
		temp_is(~s);
		expv = ~s;
		s = rnd();
		temp_sample = s;
		cfg_w(8'h60);
		idle(450);
		temp_is(expv);
		cfg_w(8'h00);
		idle(220);
		temp_is(s);
		s = rnd();
		temp_sample = s;
		cfg_w(8'h40);
		idle(70);
		temp_is(s);
		temp_sample = 16'h7fff;
		cfg_w(8'h30);
		idle(220);
		pins_are(hits(16'h7fff));
		reg_acc(8'h02, 1'b1, 8'h00);
		check(16'({crit_oe_n, lim_oe_n}), 16'h0003);
		a_lo = 1'b1;
		a_hi = 1'b1;
		idle(8);
		i2c_controller_model_inst.access({temp_sense_pkg::ADDR_BASE[6:2],
			2'b00}, 8'h03, 1'b1, 8'h00, q, ok);
		check(16'(ok), 16'h0000);
		reg_acc(8'h03, 1'b1, 8'h00);
		check(16'(q), 16'(cfg));
		close_out();
	end
endmodule : temp_conversion_and_limit_alerts_tb_top

`default_nettype wire
